// *** key_operator.sv ***
// operator model: one level key press at a time
// assumes the block's pclk
`timescale 1ns/1ps
module key_operator (
  input wire logic pclk,
  output logic level_key
);
  initial level_key = 1'b0;
  task automatic press(input int hold);
    @(posedge pclk);
    level_key <= 1'b1;
    repeat (hold) @(posedge pclk);
    level_key <= 1'b0;
    // twelve cycles, enough for the bench's short debounce and the level to land
    repeat (12) @(posedge pclk);
  endtask
endmodule

// *** level_menu_and_lifetime_monitor.sv ***
// level menu controller with capacitor running-time monitor and self-diagnosis lockout
// assumes key and fault inputs synchronous to pclk; registers reached over APB
//
// How it works
// - after reset the block sits in the operation level
// - measuring in operation and adjustment levels except during the reset pulse or a diagnosis error, halted in setting levels
// - short press in operation goes to common adjustment
// - short press in common adjustment goes to power adjustment
// - short press in power goes to temperature, then back to operation
// - one second held flashes display, two more enter initial setting
// - short press in initial setting goes to communications level one
// - short press in communications one goes to communications two
// - short press in communications two returns to initial setting
// - one second held in setting levels returns to operation
// - leaving a halted level for operation fires the power-on reset pulse
// - aging indicator lights once running time reaches the guideline
// - running-time function enabled by a control bit, off at reset
// - present running time readable by the host as a fraction of the guideline, enabled or not; reads 0 while the guideline is 0
// - running-time fault sets status bit 14 until reset
// - diagnosis error: red led, ports off, alarm and error outputs off
// - diagnosis error blanks displays or shows error glyph, chosen by control
// - entering initial setting forces alarm and error contacts off
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
module level_menu_and_lifetime_monitor
  import level_menu_pkg::*;
#(
  parameter int unsigned SHORT_CYC = SHORT_LIMIT_CYC,
  parameter int unsigned HOLD_CYC = INIT_HOLD_CYC,
  parameter int unsigned DEB_CYC = DEBOUNCE_CYC,
  parameter int unsigned TICK_CYC = CLK_HZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic level_key,
  input wire logic alarm_req,
  input wire logic error_req,
  input wire logic run_fault,
  input wire logic mem_fault,
  output level_t level,
  output panel_t panel
);

  localparam int CW = 32;

  level_t lv_q, lv_d;
  logic [CW-1:0] press_q, press_d;
  logic [CW-1:0] deb_q, deb_d;
  logic key_q, key_d;
  logic flashed_q, flashed_d;
  logic long_done_q, long_done_d;
  logic [4:0] por_q, por_d;
  logic diag_q, diag_d;
  logic run_err_q, run_err_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] limit_q, limit_d;
  logic [31:0] run_q, run_d;
  logic [CW-1:0] tick_q, tick_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  panel_t panel_d;
  // working copies of the tick and panel decisions; the panel ones are shared by several outputs
  logic tick_done;
  logic halted_now;
  logic contacts_ok;

  function automatic logic is_halted(input level_t l);
    is_halted = (l == LV_INIT) || (l == LV_COMM1) || (l == LV_COMM2);
  endfunction

  function automatic level_t short_next(input level_t l);
    case (l)
      LV_OPER: short_next = LV_ADJ_COMMON;
      LV_ADJ_COMMON: short_next = LV_ADJ_POWER;
      LV_ADJ_POWER: short_next = LV_ADJ_TEMP;
      LV_ADJ_TEMP: short_next = LV_OPER;
      LV_INIT: short_next = LV_COMM1;
      LV_COMM1: short_next = LV_COMM2;
      LV_COMM2: short_next = LV_INIT;
      default: short_next = LV_OPER;
    endcase
  endfunction

  wire logic apb_wr = psel && penable && pwrite;
  wire logic apb_rd = psel && penable && !pwrite;

  // key debounce, press timing and level walk
  always_comb begin
    lv_d = lv_q;
    press_d = press_q;
    deb_d = deb_q;
    key_d = key_q;
    flashed_d = flashed_q;
    long_done_d = long_done_q;
    por_d = por_q;
    // the reset pulse runs down on its own once started
    if (por_q != 5'h00) begin
      por_d = por_q - 5'h01;
    end
    // a raw level must stay changed for the whole debounce window before it counts
    if (level_key != key_q) begin
      deb_d = deb_q + 1;
      if (deb_q >= CW'(DEB_CYC)) begin
        key_d = level_key;
        deb_d = '0;
      end
    end else begin
      deb_d = '0;
    end
    if (diag_q) begin
      press_d = '0;
      flashed_d = 1'b0;
      long_done_d = 1'b0;
    end else if (key_q) begin
      if (press_q != '1) press_d = press_q + 1;
      if (!long_done_q && press_q + 1 >= CW'(SHORT_CYC)) begin
        if (is_halted(lv_q)) begin
          lv_d = LV_OPER;
          long_done_d = 1'b1;
          por_d = 5'(POR_PULSE_CYC);
        end else begin
          flashed_d = 1'b1;
          if (press_q + 1 >= CW'(SHORT_CYC) + CW'(HOLD_CYC)) begin
            lv_d = LV_INIT;
            long_done_d = 1'b1;
            flashed_d = 1'b0;
          end
        end
      end
    end else begin
      if (press_q != '0 && press_q < CW'(SHORT_CYC) && !long_done_q) begin
        lv_d = short_next(lv_q);
      end
      press_d = '0;
      flashed_d = 1'b0;
      long_done_d = 1'b0;
    end
  end

  // diagnosis latch and running time
  always_comb begin
    diag_d = diag_q | mem_fault;
    run_err_d = run_err_q | run_fault;
    run_d = run_q;
    tick_d = tick_q;
    tick_done = (tick_q + 1 >= CW'(TICK_CYC));
    // running time counts seconds only while enabled; a faulted counter freezes
    if (ctrl_q[CTRL_USE_RUN_BIT] && !run_err_q) begin
      if (tick_done) begin
        tick_d = '0;
        // saturate rather than wrap, so a worn unit never looks new again
        if (run_q != '1) begin
          run_d = run_q + 32'h1;
        end
      end else begin
        tick_d = tick_q + 1;
      end
    end
  end

  // software settings, written in the access phase only
  always_comb begin
    ctrl_d = ctrl_q;
    limit_d = limit_q;
    if (apb_wr) begin
      case (paddr)
        CTRL_OFF: begin
          ctrl_d = pwdata & 32'h0000_0003;
        end
        RUN_LIMIT_OFF: begin
          limit_d = pwdata;
        end
        default: begin
        end
      endcase
    end
  end

  // apb read answer and front panel
  always_comb begin
    prdata_d = 32'h0;
    pslverr_d = 1'b0;
    // every access is answered in the cycle after its setup edge
    pready_d = psel && !penable;
    halted_now = is_halted(lv_d);
    contacts_ok = !halted_now && !diag_d && (por_d == 5'h00);
    if (psel && !penable) begin
      case (paddr)
        CTRL_OFF: begin
          prdata_d = ctrl_q;
        end
        STATUS_OFF: begin
          prdata_d = 32'(run_err_q) << STATUS_RUN_ERR_BIT;
        end
        // fraction of guideline in 1/65536 units, readable with the function off
        RUN_NOW_OFF: begin
          if (limit_q != 32'h0) begin
            prdata_d = 32'((64'(run_q) << 16) / 64'(limit_q));
          end
        end
        RUN_LIMIT_OFF: begin
          prdata_d = limit_q;
        end
        DIAG_OFF: begin
          prdata_d = {25'h0, lv_q};
        end
        default: begin
          pslverr_d = 1'b1;
        end
      endcase
    end
    panel_d.measure_run = !halted_now && (por_d == 5'h00) && !diag_d;
    panel_d.por_pulse = (por_d != 5'h00);
    // contacts stay off through setting levels, the reset pulse and a diagnosis error
    panel_d.alarm_out = alarm_req && contacts_ok;
    panel_d.error_out = error_req && contacts_ok;
    panel_d.comm_enable = !diag_d;
    panel_d.alarm_led_red = diag_d;
    panel_d.display_blank = diag_d && ctrl_q[CTRL_BLANK_BIT];
    panel_d.err_glyph = diag_d && !ctrl_q[CTRL_BLANK_BIT];
    panel_d.fast_flash = flashed_d && !diag_d;
    panel_d.aging_indicator = ctrl_q[CTRL_USE_RUN_BIT] && (limit_q != 32'h0) &&
      (run_d >= limit_q) && !(diag_d && ctrl_q[CTRL_BLANK_BIT]);
  end

  // key and level state; clk_en low holds every register, the bus answer included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lv_q <= LV_OPER;
      press_q <= '0;
      deb_q <= '0;
      key_q <= 1'b0;
      flashed_q <= 1'b0;
      long_done_q <= 1'b0;
      por_q <= 5'h00;
    end else if (clk_en) begin
      lv_q <= lv_d;
      press_q <= press_d;
      deb_q <= deb_d;
      key_q <= key_d;
      flashed_q <= flashed_d;
      long_done_q <= long_done_d;
      por_q <= por_d;
    end
  end

  // fault flags and running time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_q <= 1'b0;
      run_err_q <= 1'b0;
      run_q <= 32'h0;
      tick_q <= '0;
    end else if (clk_en) begin
      diag_q <= diag_d;
      run_err_q <= run_err_d;
      run_q <= run_d;
      tick_q <= tick_d;
    end
  end

  // software settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      limit_q <= RUN_LIMIT_RST;
    end else if (clk_en) begin
      ctrl_q <= ctrl_d;
      limit_q <= limit_d;
    end
  end

  // outputs come straight from these flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      level <= LV_OPER;
      panel <= '0;
    end else if (clk_en) begin
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
      level <= lv_d;
      panel <= panel_d;
    end
  end

endmodule

// *** level_menu_and_lifetime_monitor_test.sv ***
// self-checking bench for the level menu block
// assumes short counts: short 50, hold 100, debounce 2, tick 10
`timescale 1ns/1ps
module level_menu_and_lifetime_monitor_test;
  import level_menu_pkg::*;
  typedef struct {int h; level_t lv; logic run;} row_t;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, level_key;
  logic alarm_req, error_req, run_fault, mem_fault, er, clk_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  level_t level;
  panel_t panel;
  int num_errors = 0;
  int num_checks = 0;
  row_t rows[10] = '{'{20, LV_ADJ_COMMON, 1}, '{20, LV_ADJ_POWER, 1}, '{20, LV_ADJ_TEMP, 1},
    '{20, LV_OPER, 1}, '{200, LV_INIT, 0}, '{20, LV_COMM1, 0}, '{20, LV_COMM2, 0},
    '{20, LV_INIT, 0}, '{20, LV_COMM1, 0}, '{80, LV_OPER, 1}};
  always #5 pclk = ~pclk;
  key_operator key_operator_inst (.pclk(pclk), .level_key(level_key));
  level_menu_and_lifetime_monitor #(.SHORT_CYC(50), .HOLD_CYC(100), .DEB_CYC(2), .TICK_CYC(10))
    level_menu_and_lifetime_monitor_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .level_key(level_key),
    .alarm_req(alarm_req), .error_req(error_req), .run_fault(run_fault),
    .mem_fault(mem_fault), .level(level), .panel(panel));
  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", pready, 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, run_fault, mem_fault} = '0;
    {alarm_req, error_req} = 2'b11;
    clk_en = 1'b1;
    repeat (2) @(posedge pclk);
    chk("reset level", level, LV_OPER);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("run", panel.measure_run, 1);
    apb(0, CTRL_OFF, 0);
    chk("ctrl", rd, CTRL_RST);
    apb(0, RUN_LIMIT_OFF, 0);
    chk("limit", rd, RUN_LIMIT_RST);
    apb(1, 12'h0ff, 0);
    chk("unmapped", er, 1);
    $display("test reset done");
    foreach (rows[i]) begin
      fork
        key_operator_inst.press(rows[i].h);
        begin
          repeat (61) @(posedge pclk);
          chk("flash", panel.fast_flash, rows[i].h == 200);
          chk("por", panel.por_pulse, rows[i].h == 80);
        end
      join
      chk("level", level, rows[i].lv);
      chk("run", panel.measure_run, rows[i].run);
      chk("alarm", panel.alarm_out, rows[i].run);
      chk("error", panel.error_out, rows[i].run);
    end
    clk_en <= 1'b0;
    key_operator_inst.press(20);
    clk_en <= 1'b1;
    chk("frozen level", level, LV_OPER);
    {alarm_req, error_req} <= 2'b01;
    repeat (2) @(posedge pclk);
    chk("alarm follows", panel.alarm_out, 0);
    chk("error follows", panel.error_out, 1);
    {alarm_req, error_req} <= 2'b11;
    $display("test enable and contacts done");
    apb(0, DIAG_OFF, 0);
    chk("level reg", rd, LV_OPER);
    $display("test levels done");
    apb(1, RUN_LIMIT_OFF, 1);
    repeat (40) @(posedge pclk);
    chk("aging off", panel.aging_indicator, 0);
    apb(1, CTRL_OFF, 3);
    repeat (40) @(posedge pclk);
    chk("aging", panel.aging_indicator, 1);
    run_fault <= 1'b1;
    @(posedge pclk);
    run_fault <= 1'b0;
    apb(0, STATUS_OFF, 0);
    chk("run err", rd[14], 1);
    apb(1, CTRL_OFF, 2);
    apb(0, RUN_NOW_OFF, 0);
    chk("fraction", rd, 32'h0004_0000);
    chk("aging gated", panel.aging_indicator, 0);
    $display("test running time done");
    mem_fault <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("red", panel.alarm_led_red, 1);
    chk("comm", panel.comm_enable, 0);
    chk("blank", panel.display_blank, 1);
    chk("alarm diag", panel.alarm_out, 0);
    chk("error diag", panel.error_out, 0);
    apb(1, CTRL_OFF, 0);
    repeat (2) @(posedge pclk);
    chk("glyph", panel.err_glyph, 1);
    chk("no blank", panel.display_blank, 0);
    key_operator_inst.press(20);
    chk("locked", level, LV_OPER);
    mem_fault <= 1'b0;
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(0, STATUS_OFF, 0);
    chk("run err clr", rd[14], 0);
    chk("red clr", panel.alarm_led_red, 0);
    $display("test faults done");
    results();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    results();
  end
endmodule
bind level_menu_and_lifetime_monitor level_menu_properties level_menu_properties_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .level(level), .panel(panel));

// *** level_menu_pkg.sv ***
// package for the level menu and lifetime monitor: register map, timing and carriers
// assumes a 100 MHz pclk; times are kept in ms and turned into cycle counts here
package level_menu_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SHORT_LIMIT_MS = 1000;
  localparam int unsigned INIT_HOLD_MS = 2000;
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned SHORT_LIMIT_CYC = SHORT_LIMIT_MS * (CLK_HZ / 1000);
  localparam int unsigned INIT_HOLD_CYC = INIT_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned POR_PULSE_CYC = 16;

  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam logic [11:0] RUN_NOW_OFF = 12'h008;
  localparam logic [11:0] RUN_LIMIT_OFF = 12'h00c;
  localparam logic [11:0] DIAG_OFF = 12'h010;

  localparam int unsigned CTRL_USE_RUN_BIT = 0;
  localparam int unsigned CTRL_BLANK_BIT = 1;
  localparam int unsigned STATUS_RUN_ERR_BIT = 14;
  localparam logic [31:0] RUN_LIMIT_RST = 32'h0001_0000;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  typedef enum logic [6:0] {
    LV_OPER = 7'h01,
    LV_ADJ_COMMON = 7'h02,
    LV_ADJ_POWER = 7'h04,
    LV_ADJ_TEMP = 7'h08,
    LV_INIT = 7'h10,
    LV_COMM1 = 7'h20,
    LV_COMM2 = 7'h40
  } level_t;

  typedef struct packed {
    logic measure_run;
    logic por_pulse;
    logic alarm_out;
    logic error_out;
    logic comm_enable;
    logic alarm_led_red;
    logic display_blank;
    logic err_glyph;
    logic fast_flash;
    logic aging_indicator;
  } panel_t;

endpackage

// *** level_menu_properties.sv ***
// checker for the level menu block, port level only
// assumes a bind from the bench; one clock, async reset
`timescale 1ns/1ps
module level_menu_properties
  import level_menu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input level_t level,
  input panel_t panel
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence por_run_s; panel.por_pulse [*8]; endsequence
  apb_answer_a: assert property (setup_s |=> pready && penable)
    else $error("no answer after setup");
  apb_err_a: assert property (pslverr |-> pready) else $error("stray error");
  halt_run_a: assert property ($stable(level) && level inside {LV_INIT, LV_COMM1, LV_COMM2}
    |-> !panel.measure_run) else $error("measuring in setting level");
  oper_exit_a: assert property ($past(level) == LV_OPER && level != LV_OPER
    |-> level inside {LV_ADJ_COMMON, LV_INIT}) else $error("bad exit");
  comm_exit_a: assert property ($past(level) == LV_COMM2 && level != LV_COMM2
    |-> level inside {LV_INIT, LV_OPER}) else $error("bad exit");
  por_run_a: assert property ($rose(panel.por_pulse) |-> (level == LV_OPER) ##0 por_run_s)
    else $error("bad reset pulse");
  init_off_a: assert property ($stable(level) && level == LV_INIT
    |-> !panel.alarm_out && !panel.error_out) else $error("contacts on");
  diag_off_a: assert property (panel.alarm_led_red && $past(panel.alarm_led_red)
    |-> !panel.comm_enable && !panel.alarm_out) else $error("diag outputs");
  diag_latch_a: assert property (panel.alarm_led_red |=> panel.alarm_led_red && $stable(level))
    else $error("diag not latched");
  flash_lvl_a: assert property (panel.fast_flash && $stable(level)
    |-> level inside {LV_OPER, LV_ADJ_COMMON, LV_ADJ_POWER, LV_ADJ_TEMP})
    else $error("flash in setting level");
endmodule
